// >>> rtl/ipr_pkg.sv
// Package: constants, field layout and carrier types for the input PLL reference select control
// Functional notes
// - Independent bit set: secondary uses own divider words
// - Independent bit clear: secondary copies primary divide setting
// - Fail-safe set: clock failure forces tune voltage midsupply
// - Fail-safe clear: failure tristates pump, tune follows
// - Pin mode off: codes pick nonrevertive/revert/force
// - Pin mode on: pin low primary, high secondary
// - Secondary bypass equals divide word zero or one
// - Bypassed divider divides by exactly one
// - Bit zero bypasses primary divider, clear divides
// - Zero resistor code maps to kilohm value/external
package ipr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned KOHM_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_MISC = 12'h0_01c;
  localparam logic [ADDR_W-1:0] IDX_LOOP_ZERO_RESISTOR = 12'h0_01d;
  localparam logic [ADDR_W-1:0] ADDR_MISC = IDX_MISC << 2;
  localparam logic [ADDR_W-1:0] ADDR_LOOP_ZERO_RESISTOR = IDX_LOOP_ZERO_RESISTOR << 2;

  // Miscellaneous register fields
  localparam int unsigned MISC_INDEP_BIT = 7;
  localparam int unsigned MISC_FAILSAFE_BIT = 6;
  localparam int unsigned MISC_SEL_HI = 4;
  localparam int unsigned MISC_SEL_LO = 2;
  localparam int unsigned MISC_BYP_SEC_BIT = 1;
  localparam int unsigned MISC_BYP_PRI_BIT = 0;
  localparam logic [7:0] MISC_WMASK = 8'hd_f;
  localparam logic [7:0] MISC_RESET = 8'h0_0;

  // Zero resistor register fields
  localparam logic [7:0] LOOP_ZERO_RESISTOR_WMASK = 8'h0_f;
  localparam logic [7:0] LOOP_ZERO_RESISTOR_RESET = 8'h0_0;
  localparam logic [3:0] LOOP_ZERO_RESISTOR_CODE_EXT = 4'h8;

  localparam logic [KOHM_W-1:0] KOHM_883 = 10'd883;
  localparam logic [KOHM_W-1:0] KOHM_677 = 10'd677;
  localparam logic [KOHM_W-1:0] KOHM_341 = 10'd341;
  localparam logic [KOHM_W-1:0] KOHM_135 = 10'd135;
  localparam logic [KOHM_W-1:0] KOHM_10 = 10'd10;
  localparam logic [KOHM_W-1:0] KOHM_NONE = 10'd0;

  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0_001;

  typedef enum logic [2:0] {
    IPR_SEL_NONREV = 3'b000,
    IPR_SEL_REVERT = 3'b001,
    IPR_SEL_FORCE_PRI = 3'b010,
    IPR_SEL_FORCE_SEC = 3'b011
  } ipr_sel_mode_t;

  typedef enum logic {
    IPR_REF_PRI = 1'b0,
    IPR_REF_SEC = 1'b1
  } ipr_ref_t;

  // Divider words from the divider register bank
  typedef struct packed {
    logic [DIV_W-1:0] pri_word;
    logic [DIV_W-1:0] sec_word;
  } ipr_div_words_t;

  // Clock health from the loss-of-reference and feedback monitors
  typedef struct packed {
    logic pri_fail;
    logic sec_fail;
    logic fb_fail;
  } ipr_health_t;

  // Controls handed to the analog reference path
  typedef struct packed {
    logic [DIV_W-1:0] pri_ratio;
    logic [DIV_W-1:0] sec_ratio;
    logic pri_bypass;
    logic sec_bypass;
    ipr_ref_t active_ref;
    logic tune_mid;
    logic pump_tristate;
    logic [KOHM_W-1:0] loop_zero_resistor_kohm;
    logic loop_zero_resistor_external;
  } ipr_ctrl_t;

endpackage

// >>> rtl/ipr_ref_select_ctrl.sv
// Input PLL reference select, divider bypass, fail-safe and zero resistor control with APB registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module ipr_ref_select_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference path inputs
  input wire logic ref_select_pin,
  input wire ipr_pkg::ipr_div_words_t div_words,
  input wire ipr_pkg::ipr_health_t health,
  // Reference path controls
  output ipr_pkg::ipr_ctrl_t ctrl
);

  function automatic logic [ipr_pkg::KOHM_W-1:0] loop_zero_resistor_value(input logic [3:0] code);
    logic [ipr_pkg::KOHM_W-1:0] v;
    v = ipr_pkg::KOHM_NONE;
    case (code)
      4'h0: v = ipr_pkg::KOHM_883;
      4'h1: v = ipr_pkg::KOHM_677;
      4'h2: v = ipr_pkg::KOHM_341;
      4'h3: v = ipr_pkg::KOHM_135;
      4'h4, 4'h5, 4'h6, 4'h7: v = ipr_pkg::KOHM_10;
      default: v = ipr_pkg::KOHM_NONE;
    endcase
    return v;
  endfunction

  logic [7:0] misc_q;
  logic [7:0] misc_d;
  logic [7:0] loop_zero_resistor_q;
  logic [7:0] loop_zero_resistor_d;
  logic [31:0] prdata_d;
  logic sel_meta_q;
  logic sel_sync_q;
  ipr_pkg::ipr_ref_t ref_q;
  ipr_pkg::ipr_ref_t ref_d;
  ipr_pkg::ipr_ctrl_t ctrl_d;

  // Bus decode
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_misc = (paddr == ipr_pkg::ADDR_MISC);
  wire hit_loop_zero_resistor = (paddr == ipr_pkg::ADDR_LOOP_ZERO_RESISTOR);
  wire mapped = hit_misc || hit_loop_zero_resistor;
  wire wr_misc = access_ph && pwrite && hit_misc;
  wire wr_loop_zero_resistor = access_ph && pwrite && hit_loop_zero_resistor;

  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;

  // Reserved bits are masked on write so they always read zero
  assign misc_d = wr_misc ? (pwdata[7:0] & ipr_pkg::MISC_WMASK) : misc_q;
  assign loop_zero_resistor_d = wr_loop_zero_resistor ? (pwdata[7:0] & ipr_pkg::LOOP_ZERO_RESISTOR_WMASK) : loop_zero_resistor_q;
  assign prdata_d = !setup_ph ? prdata : hit_misc ? {24'h00_0000, misc_q} :
                    hit_loop_zero_resistor ? {24'h00_0000, loop_zero_resistor_q} : 32'h0000_0000;

  // Field views
  wire indep = misc_q[ipr_pkg::MISC_INDEP_BIT];
  wire failsafe = misc_q[ipr_pkg::MISC_FAILSAFE_BIT];
  wire pin_mode = misc_q[ipr_pkg::MISC_SEL_HI];
  wire [2:0] sel_code = misc_q[ipr_pkg::MISC_SEL_HI:ipr_pkg::MISC_SEL_LO];
  wire byp_sec_bit = misc_q[ipr_pkg::MISC_BYP_SEC_BIT];
  wire byp_pri_bit = misc_q[ipr_pkg::MISC_BYP_PRI_BIT];
  wire [3:0] loop_zero_resistor_code = loop_zero_resistor_q[3:0];

  // Secondary word follows the primary unless independent control is on
  wire [ipr_pkg::DIV_W-1:0] sec_src = indep ? div_words.sec_word : div_words.pri_word;
  // Word values 0 and 1 behave as bypass
  wire pri_word_byp = (div_words.pri_word <= ipr_pkg::DIV_ONE);
  wire sec_word_byp = (sec_src <= ipr_pkg::DIV_ONE);
  wire pri_byp = byp_pri_bit || pri_word_byp;
  wire sec_byp = byp_sec_bit || sec_word_byp;

  // Reference selection; automatic modes start on the primary after reset
  always_comb
  begin
    ref_d = ref_q;
    if (pin_mode)
    begin
      ref_d = sel_sync_q ? ipr_pkg::IPR_REF_SEC : ipr_pkg::IPR_REF_PRI;
    end
    else
    begin
      case (ipr_pkg::ipr_sel_mode_t'(sel_code))
        ipr_pkg::IPR_SEL_NONREV:
        begin
          // Once moved to the secondary, stay there until it fails while the primary is healthy
          if (ref_q == ipr_pkg::IPR_REF_PRI && health.pri_fail && !health.sec_fail)
            ref_d = ipr_pkg::IPR_REF_SEC;
          else if (ref_q == ipr_pkg::IPR_REF_SEC && health.sec_fail && !health.pri_fail)
            ref_d = ipr_pkg::IPR_REF_PRI;
        end
        ipr_pkg::IPR_SEL_REVERT:
        begin
          if (!health.pri_fail)
            ref_d = ipr_pkg::IPR_REF_PRI;
          else if (!health.sec_fail)
            ref_d = ipr_pkg::IPR_REF_SEC;
        end
        ipr_pkg::IPR_SEL_FORCE_PRI: ref_d = ipr_pkg::IPR_REF_PRI;
        ipr_pkg::IPR_SEL_FORCE_SEC: ref_d = ipr_pkg::IPR_REF_SEC;
        default: ref_d = ref_q;
      endcase
    end
  end

  // Input clock failure means the reference now in use has failed
  wire in_fail = (ref_d == ipr_pkg::IPR_REF_SEC) ? health.sec_fail : health.pri_fail;
  wire clk_fail = in_fail || health.fb_fail;

  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.pri_ratio = pri_byp ? ipr_pkg::DIV_ONE : div_words.pri_word;
    ctrl_d.sec_ratio = sec_byp ? ipr_pkg::DIV_ONE : sec_src;
    ctrl_d.pri_bypass = pri_byp;
    ctrl_d.sec_bypass = sec_byp;
    ctrl_d.active_ref = ref_d;
    ctrl_d.tune_mid = failsafe && clk_fail;
    ctrl_d.pump_tristate = !failsafe && clk_fail;
    ctrl_d.loop_zero_resistor_kohm = loop_zero_resistor_value(loop_zero_resistor_code);
    ctrl_d.loop_zero_resistor_external = (loop_zero_resistor_code == ipr_pkg::LOOP_ZERO_RESISTOR_CODE_EXT);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      misc_q <= ipr_pkg::MISC_RESET;
      loop_zero_resistor_q <= ipr_pkg::LOOP_ZERO_RESISTOR_RESET;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      misc_q <= misc_d;
      loop_zero_resistor_q <= loop_zero_resistor_d;
      prdata <= prdata_d;
    end
  end

  // Select pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= ref_select_pin;
      sel_sync_q <= sel_meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_q <= ipr_pkg::IPR_REF_PRI;
      ctrl <= '0;
    end
    else
    begin
      ref_q <= ref_d;
      ctrl <= ctrl_d;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  indep_share_a: assert property (!indep && !sec_byp |=> ctrl.sec_ratio == $past(div_words.pri_word))
    else $error("secondary ratio does not follow primary word");
  indep_own_a: assert property (indep && !sec_byp |=> ctrl.sec_ratio == $past(div_words.sec_word))
    else $error("secondary ratio does not use its own word");
  fail_mid_a: assert property (failsafe && health.fb_fail |=> ctrl.tune_mid && !ctrl.pump_tristate)
    else $error("tune voltage not forced midsupply on failure");
  fail_tristate_a: assert property (!failsafe && health.fb_fail |=> ctrl.pump_tristate && !ctrl.tune_mid)
    else $error("pump not tristated on failure");
  force_ref_a: assert property (!pin_mode && sel_code[1] |=> ctrl.active_ref == ipr_pkg::ipr_ref_t'($past(sel_code[0])))
    else $error("forced reference not applied");
  revert_pri_a: assert property (!pin_mode && sel_code == 3'b001 && !health.pri_fail
    |=> ctrl.active_ref == ipr_pkg::IPR_REF_PRI)
    else $error("revertive mode did not return to primary");
  nonrev_stay_a: assert property (!pin_mode && sel_code == 3'b000 && ref_q == ipr_pkg::IPR_REF_SEC && !health.sec_fail
    |=> ref_q == ipr_pkg::IPR_REF_SEC)
    else $error("nonrevertive mode left the secondary");
  pin_follow_a: assert property (pin_mode && $stable(pin_mode) ##1 pin_mode
    |-> ctrl.active_ref == ipr_pkg::ipr_ref_t'($past(sel_sync_q)))
    else $error("pin mode does not follow the select pin");
  sec_bypass_a: assert property (byp_sec_bit |=> ctrl.sec_ratio == ipr_pkg::DIV_ONE && ctrl.sec_bypass)
    else $error("secondary bypass ratio not one");
  pri_bypass_a: assert property (byp_pri_bit |=> ctrl.pri_ratio == ipr_pkg::DIV_ONE && ctrl.pri_bypass)
    else $error("primary bypass ratio not one");
  pri_normal_a: assert property (!byp_pri_bit && !pri_word_byp |=> ctrl.pri_ratio == $past(div_words.pri_word))
    else $error("primary divider not dividing normally");
  loop_zero_resistor_map_a: assert property (loop_zero_resistor_code == 4'h1 |=> ctrl.loop_zero_resistor_kohm == ipr_pkg::KOHM_677 && !ctrl.loop_zero_resistor_external)
    else $error("zero resistor code one not mapped");
  loop_zero_resistor_ext_a: assert property (loop_zero_resistor_code == ipr_pkg::LOOP_ZERO_RESISTOR_CODE_EXT
    |=> ctrl.loop_zero_resistor_external && ctrl.loop_zero_resistor_kohm == ipr_pkg::KOHM_NONE)
    else $error("external zero resistor not selected");
  reserved_zero_a: assert property (wr_misc ##1 psel && !penable && hit_misc ##1 1'b1
    |-> prdata[5] == 1'b0 && prdata[31:8] == 24'h00_0000)
    else $error("reserved bits read back nonzero");

  // Divider word values of zero or one must look exactly like the bypass bit
  sec_word_byp_a: assert property (sec_word_byp && !byp_sec_bit
    |=> ctrl.sec_bypass && ctrl.sec_ratio == ipr_pkg::DIV_ONE)
    else $error("secondary word bypass not applied");
  pri_word_byp_a: assert property (pri_word_byp && !byp_pri_bit
    |=> ctrl.pri_bypass && ctrl.pri_ratio == ipr_pkg::DIV_ONE)
    else $error("primary word bypass not applied");
  sec_normal_a: assert property (!byp_sec_bit && !sec_word_byp
    |=> !ctrl.sec_bypass && ctrl.sec_ratio == $past(sec_src))
    else $error("secondary divider not dividing normally");
  pri_flag_a: assert property (!byp_pri_bit && !pri_word_byp
    |=> !ctrl.pri_bypass)
    else $error("primary bypass flag set without cause");

  // An input failure counts only for the reference that is in use
  in_fail_mid_a: assert property (failsafe && ref_d == ipr_pkg::IPR_REF_PRI && health.pri_fail
    |=> ctrl.tune_mid && !ctrl.pump_tristate)
    else $error("input failure did not force midsupply");
  in_fail_tri_a: assert property (!failsafe && ref_d == ipr_pkg::IPR_REF_SEC && health.sec_fail
    |=> ctrl.pump_tristate && !ctrl.tune_mid)
    else $error("input failure did not tristate the pump");
  healthy_quiet_a: assert property (!health.pri_fail && !health.sec_fail && !health.fb_fail
    |=> !ctrl.tune_mid && !ctrl.pump_tristate)
    else $error("fail-safe action without a clock failure");
  tune_exclusive_a: assert property (!(ctrl.tune_mid && ctrl.pump_tristate))
    else $error("midsupply and tristate both requested");

  // Reference selection: switching away from a failed primary, forced primary and a high select pin
  nonrev_move_a: assert property (!pin_mode && sel_code == 3'b000 && ref_q == ipr_pkg::IPR_REF_PRI
    && health.pri_fail && !health.sec_fail
    |=> ctrl.active_ref == ipr_pkg::IPR_REF_SEC)
    else $error("nonrevertive mode did not leave failed primary");
  revert_sec_a: assert property (!pin_mode && sel_code == 3'b001 && health.pri_fail && !health.sec_fail
    |=> ctrl.active_ref == ipr_pkg::IPR_REF_SEC)
    else $error("revertive mode did not fall back to secondary");
  force_pri_a: assert property (!pin_mode && sel_code == 3'b010
    |=> ctrl.active_ref == ipr_pkg::IPR_REF_PRI)
    else $error("forced primary not applied");
  pin_sec_a: assert property (pin_mode && sel_sync_q
    |=> ctrl.active_ref == ipr_pkg::IPR_REF_SEC)
    else $error("high select pin did not pick secondary");

  // Zero resistor decode, including the codes left undefined
  loop_zero_resistor_top_a: assert property (loop_zero_resistor_code == 4'h0
    |=> ctrl.loop_zero_resistor_kohm == ipr_pkg::KOHM_883 && !ctrl.loop_zero_resistor_external)
    else $error("zero resistor code zero not mapped");
  loop_zero_resistor_low_a: assert property (loop_zero_resistor_code[3:2] == 2'b01
    |=> ctrl.loop_zero_resistor_kohm == ipr_pkg::KOHM_10 && !ctrl.loop_zero_resistor_external)
    else $error("low zero resistor codes not mapped");
  loop_zero_resistor_undef_a: assert property (loop_zero_resistor_code > ipr_pkg::LOOP_ZERO_RESISTOR_CODE_EXT
    |=> ctrl.loop_zero_resistor_kohm == ipr_pkg::KOHM_NONE && !ctrl.loop_zero_resistor_external)
    else $error("undefined zero resistor code selected a value");

  // Register storage: reserved bits never stick, unmapped writes never land
  misc_rsvd_a: assert property (!misc_q[5])
    else $error("reserved misc bit stored");
  loop_zero_resistor_rsvd_a: assert property (loop_zero_resistor_q[7:4] == 4'h0)
    else $error("reserved resistor bits stored");
  misc_write_a: assert property (wr_misc
    |=> misc_q == ($past(pwdata[7:0]) & ipr_pkg::MISC_WMASK))
    else $error("misc write did not land");
  unmapped_write_a: assert property (access_ph && pwrite && !mapped
    |=> misc_q == $past(misc_q) && loop_zero_resistor_q == $past(loop_zero_resistor_q))
    else $error("unmapped write changed a register");

  pin_mode_c: cover property (pin_mode && $rose(sel_sync_q) ##2 ctrl.active_ref == ipr_pkg::IPR_REF_SEC);
  nonrev_switch_c: cover property (sel_code == 3'b000 && $rose(ref_q == ipr_pkg::IPR_REF_SEC));
  failsafe_c: cover property ($rose(ctrl.tune_mid));
  unmapped_c: cover property (pslverr);
  revert_c: cover property (sel_code == 3'b001 && $rose(ref_q == ipr_pkg::IPR_REF_PRI));

endmodule

// >>> tb/ipr_ref_select_ctrl_tb.sv
// Self-checking testbench for the input PLL reference select control block
`timescale 1ns/10ps
module ipr_ref_select_ctrl_tb;
  localparam logic [ipr_pkg::ADDR_W-1:0] misc_a = ipr_pkg::ADDR_MISC;
  localparam logic [ipr_pkg::ADDR_W-1:0] rz_a = ipr_pkg::ADDR_LOOP_ZERO_RESISTOR;
  logic pclk, presetn, psel, penable, pwrite, ref_select_pin, serr;
  logic [ipr_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  ipr_pkg::ipr_div_words_t div_words;
  ipr_pkg::ipr_health_t health;
  ipr_pkg::ipr_ctrl_t ctrl;
  int errors, samples_checked;
  wire [31:0] aref = 32'(ctrl.active_ref);
  wire [31:0] pri_v = {15'h0, ctrl.pri_bypass, ctrl.pri_ratio};
  wire [31:0] sec_v = {15'h0, ctrl.sec_bypass, ctrl.sec_ratio};
  wire [31:0] tune_v = {30'h0, ctrl.tune_mid, ctrl.pump_tristate};
  wire [31:0] rz_v = {21'h0, ctrl.loop_zero_resistor_external, ctrl.loop_zero_resistor_kohm};

  ipr_ref_select_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_select_pin(ref_select_pin), .div_words(div_words), .health(health), .ctrl(ctrl)
  );

  always #10 pclk = ~pclk;

  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("BAD %0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask

  // Settle on the falling edge so registered outputs are never read in their launch step
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic apb(input logic w, input logic [ipr_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wm(input logic [7:0] d);
    apb(1'b1, misc_a, {24'h0, d});
    wt(3);
  endtask

  // Pin goes through a two-stage synchroniser, so allow a few edges
  task automatic drv(input logic [2:0] h, input logic pin, input logic [31:0] dw);
    @(posedge pclk);
    health <= h;
    ref_select_pin <= pin;
    div_words <= dw;
    wt(4);
  endtask

  function automatic logic [31:0] rz(input int c);
    case (c)
      0: rz = 32'(ipr_pkg::KOHM_883);
      1: rz = 32'(ipr_pkg::KOHM_677);
      2: rz = 32'(ipr_pkg::KOHM_341);
      3: rz = 32'(ipr_pkg::KOHM_135);
      4, 5, 6, 7: rz = 32'(ipr_pkg::KOHM_10);
      8: rz = 32'h400;
      default: rz = 32'h0;
    endcase
  endfunction

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    ref_select_pin = 1'b0;
    div_words = 32'h0005_0009;
    health = '0;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    chk(aref, 32'h0);
    apb(1'b0, misc_a, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk({serr, rd[30:0]}, 32'h8000_0000);
    wm(8'hff);
    apb(1'b0, misc_a, 32'h0);
    chk({serr, rd[30:0]}, 32'hdf);
    apb(1'b1, rz_a, 32'hff);
    apb(1'b0, rz_a, 32'h0);
    chk(rd, 32'h0f);
    wm(8'h80);
    chk(sec_v, 32'h9);
    chk(pri_v, 32'h5);
    wm(8'h00);
    chk(sec_v, 32'h5);
    wm(8'h02);
    chk(sec_v, 32'h1_0001);
    chk(pri_v, 32'h5);
    wm(8'h01);
    chk(pri_v, 32'h1_0001);
    wm(8'h80);
    drv(3'b000, 1'b0, 32'h0005_0000);
    chk(sec_v, 32'h1_0001);
    drv(3'b000, 1'b0, 32'h0005_0009);
    wm(8'h40);
    drv(3'b001, 1'b0, 32'h0005_0009);
    chk(tune_v, 32'h2);
    wm(8'h00);
    chk(tune_v, 32'h1);
    drv(3'b000, 1'b0, 32'h0005_0009);
    chk(tune_v, 32'h0);
    drv(3'b100, 1'b0, 32'h0005_0009);
    chk(aref, 32'h1);
    drv(3'b000, 1'b0, 32'h0005_0009);
    chk(aref, 32'h1);
    wm(8'h04);
    chk(aref, 32'h0);
    drv(3'b000, 1'b1, 32'h0005_0009);
    wm(8'h08);
    chk(aref, 32'h0);
    wm(8'h0c);
    chk(aref, 32'h1);
    wm(8'h10);
    chk(aref, 32'h1);
    drv(3'b000, 1'b0, 32'h0005_0009);
    chk(aref, 32'h0);
    wm(8'h1c);
    chk(aref, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, rz_a, 32'(c));
      wt(3);
      chk(rz_v, rz(c));
    end
    finish_test();
  end
endmodule
